// File: rtl/spmp_regs.svh
// Register addresses, field positions, reset values and fixed counts of the SPI port
`ifndef SPMP_REGS_SVH
`define SPMP_REGS_SVH
`define SPMP_ADDR_CFG    8'h9A
`define SPMP_ADDR_DAT    8'h9B
`define SPMP_ADDR_RATE   8'h9D
`define SPMP_ADDR_CTRL   8'hF8
`define SPMP_RST_BYTE    8'h00
`define SPMP_RST_LEN     3'h7
`define SPMP_RST_CNT     3'h0
`define SPMP_RST_PHPOL   2'h0
`define SPMP_RST_SYNC    4'h8
`define SPMP_BIT_DONE    7
`define SPMP_BIT_WRITE_COLLISION_FLAG    6
`define SPMP_BIT_MODE_FAULT_FLAG    5
`define SPMP_BIT_OVR     4
`define SPMP_BIT_SEL     2
`define SPMP_BIT_MASTER_ENABLE   1
`define SPMP_BIT_PORT_ENABLE   0
`define SPMP_CFG_PHPOL   7:6
`define SPMP_CFG_LEN     2:0
`define SPMP_BIT_MSB     7
`define SPMP_LAST_BIT    3'h7
`define SPMP_CNT_ONE     3'h1
`define SPMP_RATE_ONE    8'h01
`define SPMP_FIFO_DEPTH  16
`endif

// File: rtl/spmp_pkg.sv
// Types shared by the SPI port
package spmp_pkg;
  typedef enum logic [1:0] {
    SPMP_IDLE   = 2'b00,
    SPMP_MASTER = 2'b01,
    SPMP_SLAVE  = 2'b10
  } spmp_state_t;

  // Control and status byte as it reads back
  typedef struct packed {
    logic transfer_done_flag;
    logic write_collision_flag;
    logic mode_fault_flag;
    logic receive_overrun_flag;
    logic master_busy_flag;
    logic slave_selected_flag;
    logic master_enable;
    logic port_enable;
  } spmp_ctrl_t;

  // Pin outputs with their enables
  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } spmp_pins_t;
endpackage : spmp_pkg

// File: rtl/spmp_top.sv
// SPI master/slave port with receive FIFO and byte-wide special register access
// Operation
// [RL1] Master shifts frame length code plus one bits
// [RL2] Slave ignores frame length, always eight bits
// [RL3] Done flag set per transfer, software clears
// [RL4] Data write during transfer sets collision flag
// [RL5] Master enable with select low sets fault
// [RL6] Full receive buffer at last bit: overrun
// [RL7] Busy flag high throughout master transfer
// [RL8] Selected flag mirrors select input low
// [RL9] Master enable chooses master, else slave
// [RL10] Port enable zero disables whole port; mode fault still sets with port enable zero if master enable and select low
// [RL11] Clock half period is rate plus one
// [RL12] Master data write starts transfer immediately
// [RL13] Data read returns receive buffer contents
// [RL14] Mode fault clears master and port enables
// [RL15] Overrun keeps old byte, drops new byte
// [RL16] Colliding write ignored, transfer continues
// [RL17] Both directions shift most significant bit first
// [RL18] External master holds select low, clocks bits
// [RL19] Slave done flag set when select rises
`timescale 1ns/1ps
`include "spmp_regs.svh"

module spmp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SPMP_FIFO_DEPTH
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // Depth must be a power of two of at least two
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("spmp_fifo: DEPTH must be a power of two >= 2");
  end

  // Handshakes on both sides
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rp_q];
  assign count     = cnt_q;
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_ready && out_valid;

  // Storage array
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : spmp_fifo

module spmp_top #(
  parameter int RX_DEPTH = `SPMP_FIFO_DEPTH
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic [7:0]      sfr_rdata,
  output logic            irq,
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       miso_i,
  input  wire logic       nss_i,
  output logic            sck_o,
  output logic            sck_oe,
  output logic            mosi_o,
  output logic            mosi_oe,
  output logic            miso_o,
  output logic            miso_oe
);
  spmp_pkg::spmp_state_t state_q;
  spmp_pkg::spmp_ctrl_t  ctrl_rd;
  spmp_pkg::spmp_pins_t  pins_q;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic       sck_prev_q;
  logic       done_q, write_collision_flag_q, mode_fault_flag_q, ovr_q, master_enable_q, port_enable_q;
  logic [2:0] len_q;
  logic [1:0] phpol_q;
  logic [7:0] rate_q;
  logic [7:0] cnt_q;
  logic [2:0] bit_q;
  logic       sck_q;
  logic       sample_q;
  logic [7:0] shreg_q;
  logic [7:0] sh_d;
  logic [7:0] sh_shift;
  logic       irq_q;
  logic       nss_low, sck_s, mosi_s, miso_s;
  logic       wr_ctrl, wr_cfg, wr_rate, wr_data, rd_data;
  logic       start_m, tick, rise_m, fall_m, s_rise, s_fall;
  logic       finish_m, slave_full, slave_end, push, done_set;
  logic       mode_fault_flag_set, write_collision_flag_set, ovr_set, rx_ready, rx_valid;
  logic [7:0] rx_head;
  logic [$clog2(RX_DEPTH):0] rx_count;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Address match used by every register strobe
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction : hit

  // Two-flop synchronisers; reset to idle pin levels so no false clock edge follows
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_q       <= `SPMP_RST_SYNC;
      s2_q       <= `SPMP_RST_SYNC;
      sck_prev_q <= 1'b0;
    end else if (ce) begin
      s1_q       <= {nss_i, miso_i, mosi_i, sck_i};
      s2_q       <= s1_q;
      sck_prev_q <= s2_q[0];
    end
  end
  assign sck_s   = s2_q[0];
  assign mosi_s  = s2_q[1];
  assign miso_s  = s2_q[2];
  assign nss_low = !s2_q[3];

  // Register strobes
  assign wr_ctrl = ce && sfr_wr && hit(sfr_addr, `SPMP_ADDR_CTRL);
  assign wr_cfg  = ce && sfr_wr && hit(sfr_addr, `SPMP_ADDR_CFG);
  assign wr_rate = ce && sfr_wr && hit(sfr_addr, `SPMP_ADDR_RATE);
  assign wr_data = ce && sfr_wr && hit(sfr_addr, `SPMP_ADDR_DAT);
  assign rd_data = ce && sfr_rd && hit(sfr_addr, `SPMP_ADDR_DAT);

  // Transfer events
  assign start_m  = wr_data && port_enable_q && master_enable_q && state_q == spmp_pkg::SPMP_IDLE
                    && !mode_fault_flag_set; // RL12 RL9
  assign tick     = state_q == spmp_pkg::SPMP_MASTER && cnt_q == rate_q; // RL11
  assign rise_m   = tick && !sck_q;
  assign fall_m   = tick && sck_q;
  assign s_rise   = state_q == spmp_pkg::SPMP_SLAVE && sck_s && !sck_prev_q;
  assign s_fall   = state_q == spmp_pkg::SPMP_SLAVE && !sck_s && sck_prev_q;
  assign finish_m = fall_m && bit_q == len_q; // RL1
  assign slave_full = s_fall && bit_q == `SPMP_LAST_BIT; // RL2
  assign slave_end  = state_q == spmp_pkg::SPMP_SLAVE && !nss_low; // RL19 RL18
  assign push     = finish_m || slave_full;
  assign done_set = finish_m || slave_end; // RL3
  assign mode_fault_flag_set = ce && master_enable_q && nss_low; // RL5
  assign write_collision_flag_set = wr_data && state_q != spmp_pkg::SPMP_IDLE; // RL4
  assign ovr_set  = push && !rx_ready; // RL6
  assign sh_shift = {shreg_q[6:0], sample_q}; // RL17

  // Port mode: idle, master transfer or selected slave
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= spmp_pkg::SPMP_IDLE;
    end else if (ce) begin
      unique case (state_q)
        spmp_pkg::SPMP_IDLE: begin
          if (start_m) state_q <= spmp_pkg::SPMP_MASTER;
          else if (port_enable_q && !master_enable_q && nss_low) state_q <= spmp_pkg::SPMP_SLAVE; // RL9
        end
        spmp_pkg::SPMP_MASTER: begin
          if (mode_fault_flag_set || !port_enable_q || finish_m) state_q <= spmp_pkg::SPMP_IDLE; // RL7 RL10
        end
        spmp_pkg::SPMP_SLAVE: begin
          if (!nss_low || !port_enable_q || master_enable_q) state_q <= spmp_pkg::SPMP_IDLE; // RL10
        end
        default: state_q <= spmp_pkg::SPMP_IDLE;
      endcase
    end
  end

  // Half-period counter and master clock
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= `SPMP_RST_BYTE;
      sck_q <= 1'b0;
    end else if (ce) begin
      if (state_q != spmp_pkg::SPMP_MASTER || start_m) begin
        cnt_q <= `SPMP_RST_BYTE;
        sck_q <= 1'b0;
      end else if (tick) begin
        cnt_q <= `SPMP_RST_BYTE;
        sck_q <= !sck_q; // RL11
      end else begin
        cnt_q <= cnt_q + `SPMP_RATE_ONE;
      end
    end
  end

  // Bit counter and input sample
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bit_q    <= `SPMP_RST_CNT;
      sample_q <= 1'b0;
    end else if (ce) begin
      if (rise_m) sample_q <= miso_s;
      else if (s_rise) sample_q <= mosi_s;
      if (state_q == spmp_pkg::SPMP_IDLE) bit_q <= `SPMP_RST_CNT;
      else if (fall_m || s_fall) bit_q <= bit_q + `SPMP_CNT_ONE;
    end
  end

  // Shift register next value; a colliding write does not touch it
  always_comb begin
    sh_d = shreg_q;
    if (start_m) sh_d = sfr_wdata; // RL12
    else if (wr_data && state_q == spmp_pkg::SPMP_IDLE) sh_d = sfr_wdata;
    else if (fall_m || s_fall) sh_d = sh_shift; // RL16 RL17
  end

  always_ff @(posedge clk_sys) begin
    if (rst) shreg_q <= `SPMP_RST_BYTE;
    else if (ce) shreg_q <= sh_d;
  end

  // Pin drivers, all registered; mosi moves with the registered sck fall, not before it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pins_q <= '0;
    end else if (ce) begin
      pins_q.sck_o   <= sck_q;
      pins_q.sck_oe  <= port_enable_q && master_enable_q; // RL10
      pins_q.mosi_o  <= shreg_q[`SPMP_BIT_MSB]; // RL17
      pins_q.mosi_oe <= port_enable_q && master_enable_q;
      pins_q.miso_o  <= sh_d[`SPMP_BIT_MSB];
      pins_q.miso_oe <= port_enable_q && !master_enable_q && nss_low;
    end
  end
  assign sck_o   = pins_q.sck_o;
  assign sck_oe  = pins_q.sck_oe;
  assign mosi_o  = pins_q.mosi_o;
  assign mosi_oe = pins_q.mosi_oe;
  assign miso_o  = pins_q.miso_o;
  assign miso_oe = pins_q.miso_oe;

  // Sticky flags: hardware set wins over a software write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      mode_fault_flag_q <= 1'b0;
      ovr_q  <= 1'b0;
    end else if (ce) begin
      if (done_set) done_q <= 1'b1; // RL3
      else if (wr_ctrl) done_q <= sfr_wdata[`SPMP_BIT_DONE];
      if (write_collision_flag_set) write_collision_flag_q <= 1'b1; // RL4
      else if (wr_ctrl) write_collision_flag_q <= sfr_wdata[`SPMP_BIT_WRITE_COLLISION_FLAG];
      if (mode_fault_flag_set) mode_fault_flag_q <= 1'b1; // RL5
      else if (wr_ctrl) mode_fault_flag_q <= sfr_wdata[`SPMP_BIT_MODE_FAULT_FLAG];
      if (ovr_set) ovr_q <= 1'b1; // RL6
      else if (wr_ctrl) ovr_q <= sfr_wdata[`SPMP_BIT_OVR];
    end
  end

  // Enables; a mode fault takes the port off-line
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      master_enable_q <= 1'b0;
      port_enable_q <= 1'b0;
    end else if (ce) begin
      if (mode_fault_flag_set) begin
        master_enable_q <= 1'b0; // RL14
        port_enable_q <= 1'b0; // RL14
      end else if (wr_ctrl) begin
        master_enable_q <= sfr_wdata[`SPMP_BIT_MASTER_ENABLE];
        port_enable_q <= sfr_wdata[`SPMP_BIT_PORT_ENABLE];
      end
    end
  end

  // Configuration and rate registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      len_q   <= `SPMP_RST_LEN;
      phpol_q <= `SPMP_RST_PHPOL;
      rate_q  <= `SPMP_RST_BYTE;
    end else if (ce) begin
      if (wr_cfg) begin
        len_q   <= sfr_wdata[`SPMP_CFG_LEN];
        phpol_q <= sfr_wdata[`SPMP_CFG_PHPOL];
      end
      if (wr_rate) rate_q <= sfr_wdata;
    end
  end

  // Receive buffer; a full buffer refuses the new byte
  spmp_fifo #(
    .WIDTH (8),
    .DEPTH (RX_DEPTH)
  ) u_rx (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (push), // RL15
    .in_ready  (rx_ready),
    .in_data   (sh_shift),
    .out_valid (rx_valid),
    .out_ready (rd_data), // RL13
    .out_data  (rx_head),
    .count     (rx_count)
  );

  // Status byte
  always_comb begin
    ctrl_rd.transfer_done_flag   = done_q;
    ctrl_rd.write_collision_flag = write_collision_flag_q;
    ctrl_rd.mode_fault_flag      = mode_fault_flag_q;
    ctrl_rd.receive_overrun_flag = ovr_q;
    ctrl_rd.master_busy_flag     = state_q == spmp_pkg::SPMP_MASTER; // RL7
    ctrl_rd.slave_selected_flag  = nss_low; // RL8
    ctrl_rd.master_enable        = master_enable_q;
    ctrl_rd.port_enable          = port_enable_q;
  end

  // Read data, registered; unmapped addresses read zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sfr_rdata <= `SPMP_RST_BYTE;
    end else if (ce && sfr_rd) begin
      if (hit(sfr_addr, `SPMP_ADDR_CTRL)) sfr_rdata <= ctrl_rd;
      else if (hit(sfr_addr, `SPMP_ADDR_CFG)) sfr_rdata <= {phpol_q, bit_q, len_q};
      else if (hit(sfr_addr, `SPMP_ADDR_RATE)) sfr_rdata <= rate_q;
      else if (hit(sfr_addr, `SPMP_ADDR_DAT)) sfr_rdata <= rx_valid ? rx_head : `SPMP_RST_BYTE; // RL13
      else sfr_rdata <= `SPMP_RST_BYTE;
    end
  end

  // Interrupt request from any set sticky flag
  always_ff @(posedge clk_sys) begin
    if (rst) irq_q <= 1'b0;
    else if (ce) irq_q <= done_q || write_collision_flag_q || mode_fault_flag_q || ovr_q;
  end
  assign irq = irq_q;

  a_mst_len: assert property (ce && fall_m && bit_q != len_q && !mode_fault_flag_set && port_enable_q // RL1
    |=> state_q == spmp_pkg::SPMP_MASTER)
    else $error("master frame ended early");
  a_slv_len: assert property (push && state_q == spmp_pkg::SPMP_SLAVE // RL2
    |-> bit_q == `SPMP_LAST_BIT)
    else $error("slave frame not eight bits");
  a_done_set: assert property (ce && done_set |=> done_q) // RL3
    else $error("done flag not set");
  a_write_collision_flag_flag: assert property (wr_data && state_q == spmp_pkg::SPMP_MASTER && !fall_m // RL4
    |=> write_collision_flag_q && shreg_q == $past(shreg_q))
    else $error("collision not flagged or write not ignored");
  a_mode_fault_flag_off: assert property (ce && master_enable_q && nss_low // RL5 RL14
    |=> mode_fault_flag_q && !master_enable_q && !port_enable_q)
    else $error("mode fault not handled");
  a_ovr_keep: assert property (ce && ovr_set && !rd_data // RL6 RL15
    |=> ovr_q && rx_count == $past(rx_count))
    else $error("overrun not handled");
  a_busy_run: assert property (start_m // RL7
    |=> ctrl_rd.master_busy_flag ##1 (ctrl_rd.master_busy_flag || !port_enable_q))
    else $error("busy not held after start");
  a_sel_read: assert property (ce && sfr_rd && hit(sfr_addr, `SPMP_ADDR_CTRL) // RL8
    |=> sfr_rdata[`SPMP_BIT_SEL] == $past(nss_low))
    else $error("selected flag mismatch");
  a_sck_hold: assert property (ce && state_q == spmp_pkg::SPMP_MASTER && !tick && !start_m // RL11
    |=> sck_q == $past(sck_q))
    else $error("sck toggled early");
  a_rd_buf: assert property (rd_data && rx_valid |=> sfr_rdata == $past(rx_head)) // RL13
    else $error("data read not from buffer");
  a_msb_first: assert property (start_m ##1 ce // RL17
    |=> mosi_o == $past(sfr_wdata[`SPMP_BIT_MSB], 2))
    else $error("first bit not msb");
endmodule : spmp_top

// File: verification/spmp_peer.sv
// Behavioural SPI slave that answers the port while it runs as master
`timescale 1ns/1ps
module spmp_peer (
  input  wire logic       sel_n,
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  logic [7:0] shift;

  // Power-up state of the reply path
  initial begin
    miso    = 1'b0;
    rx_byte = 8'h00;
    shift   = 8'h00;
  end

  // Selection loads the reply and presents its top bit first
  always @(negedge sel_n) begin
    shift   = tx_byte;
    miso    = tx_byte[7];
    rx_byte = 8'h00;
  end

  // A released line carries no valid data, so show the inverse
  always @(posedge sel_n) miso = ~miso;

  // Capture on the rising clock
  always @(posedge sck) begin
    if (!sel_n) rx_byte = {rx_byte[6:0], mosi};
  end

  // Next reply bit on the falling clock
  always @(negedge sck) begin
    if (!sel_n) begin
      shift = {shift[6:0], 1'b0};
      miso  = shift[7];
    end
  end
endmodule : spmp_peer

// File: verification/spmp_top_bench.sv
// Self-checking bench of the SPI port with a slave model on its link
`timescale 1ns/1ps
`include "spmp_regs.svh"
module spmp_top_bench;
  typedef struct packed {
    logic [7:0] rate;
    logic [2:0] len;
    logic [7:0] tx;
    logic [7:0] stx;
  } spmp_row_t;

  logic        clk_sys, rst, ce, sfr_wr, sfr_rd, irq, sel_n;
  logic        sck_i, mosi_i, miso_i, nss_i;
  logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, stx, prx, got;
  logic [15:0] hi;
  int          err_total, check_count, n;
  // Multi-bit rows keep the rate at three or more: each returned bit crosses two sync stages
  const spmp_row_t rows [5] = '{'{8'h05, 3'h7, 8'hA6, 8'h3C}, '{8'h03, 3'h0, 8'h81, 8'hC3},
    '{8'h03, 3'h3, 8'h5E, 8'h9F}, '{8'h04, 3'h5, 8'h2D, 8'h71}, '{8'hFF, 3'h0, 8'h7E, 8'h80}};

  spmp_top dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .irq(irq), .sck_i(sck_i),
    .mosi_i(mosi_i), .miso_i(miso_i), .nss_i(nss_i), .sck_o(sck_o), .sck_oe(sck_oe),
    .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_o(miso_o), .miso_oe(miso_oe));
  spmp_peer peer (.sel_n(sel_n), .sck(sck_o), .mosi(mosi_o), .tx_byte(stx), .miso(miso_i),
    .rx_byte(prx));

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  task automatic results;
    if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
  endtask : wr

  // Read one register and compare it
  task automatic rck(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    #1 got = sfr_rdata;
    chk(what, {8'h00, exp}, {8'h00, got});
  endtask : rck

  // Wait for the interrupt line, counting cycles with the serial clock high
  task automatic wait_done(output logic [15:0] cnt);
    int w;
    cnt = 16'h0000;
    w = 0;
    while (irq !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      if (sck_o === 1'b1) cnt++;
      w++;
      if (w > 6000) begin
        err_total++;
        results();
      end
    end
  endtask : wait_done

  // One master transfer with the slave model selected
  task automatic xfer(input logic [7:0] tx, input logic [7:0] s, output logic [15:0] cnt);
    stx   <= s;
    sel_n <= 1'b0;
    wr(`SPMP_ADDR_DAT, tx);
    wait_done(cnt);
    sel_n <= 1'b1;
  endtask : xfer

  // Bench acts as external master: select low throughout, eight clocks, half period 5
  task automatic drive_slave(input logic [7:0] b, output logic [7:0] cap);
    nss_i <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi_i <= b[i];
      repeat (5) @(posedge clk_sys);
      sck_i <= 1'b1;
      cap = {cap[6:0], miso_o};
      repeat (5) @(posedge clk_sys);
      sck_i <= 1'b0;
    end
    repeat (5) @(posedge clk_sys);
    nss_i  <= 1'b1;
    mosi_i <= ~b[0];
  endtask : drive_slave

  // Main sequence
  initial begin
    clk_sys = 1'b0; rst = 1'b1; ce = 1'b1; sfr_addr = 8'h00; sfr_wr = 1'b0; sfr_rd = 1'b0;
    sfr_wdata = 8'h00; sck_i = 1'b0; mosi_i = 1'b0; nss_i = 1'b1; sel_n = 1'b1; stx = 8'h00;
    err_total = 0;
    check_count = 0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rck("ctrl", `SPMP_ADDR_CTRL, 8'h00);
    rck("cfg", `SPMP_ADDR_CFG, 8'h07);
    rck("rate", `SPMP_ADDR_RATE, 8'h00);
    rck("data", `SPMP_ADDR_DAT, 8'h00);
    rck("unmapped", 8'h10, 8'h00);
    wr(`SPMP_ADDR_CTRL, 8'h03);
    @(posedge clk_sys);
    #1 chk("oe", 16'h0006, {13'h0000, sck_oe, mosi_oe, miso_oe});
    foreach (rows[i]) begin
      n = int'(rows[i].len) + 1;
      wr(`SPMP_ADDR_RATE, rows[i].rate);
      wr(`SPMP_ADDR_CFG, {5'h00, rows[i].len});
      xfer(rows[i].tx, rows[i].stx, hi);
      chk("sck high", 16'(n * (int'(rows[i].rate) + 1)), hi);
      chk("peer rx", {8'h00, 8'(rows[i].tx >> (8 - n))}, {8'h00, prx});
      rck("status", `SPMP_ADDR_CTRL, 8'h83);
      rck("data", `SPMP_ADDR_DAT, 8'((rows[i].tx << n) | (rows[i].stx >> (8 - n))));
      wr(`SPMP_ADDR_CTRL, 8'h03);
    end
    // Colliding write during a transfer
    wr(`SPMP_ADDR_CFG, 8'h07);
    wr(`SPMP_ADDR_RATE, 8'h03);
    stx   <= 8'h5A;
    sel_n <= 1'b0;
    wr(`SPMP_ADDR_DAT, 8'hC3);
    rck("busy", `SPMP_ADDR_CTRL, 8'h0B);
    wr(`SPMP_ADDR_DAT, 8'h11);
    rck("collision", `SPMP_ADDR_CTRL, 8'h4B);
    wr(`SPMP_ADDR_CTRL, 8'h03);
    repeat (2) @(posedge clk_sys);
    wait_done(hi);
    sel_n <= 1'b1;
    chk("peer rx", 16'h00C3, {8'h00, prx});
    rck("status", `SPMP_ADDR_CTRL, 8'h83);
    rck("data", `SPMP_ADDR_DAT, 8'h5A);
    // Disabled port ignores a data write
    wr(`SPMP_ADDR_CTRL, 8'h00);
    wr(`SPMP_ADDR_DAT, 8'h55);
    hi = 16'h0000;
    repeat (40) begin
      @(posedge clk_sys);
      #1;
      if (sck_oe === 1'b1 || irq === 1'b1) hi++;
    end
    chk("idle", 16'h0000, hi);
    rck("status", `SPMP_ADDR_CTRL, 8'h00);
    // Fill the receive buffer past its depth
    wr(`SPMP_ADDR_CTRL, 8'h03);
    wr(`SPMP_ADDR_RATE, 8'h02);
    wr(`SPMP_ADDR_CFG, 8'h00);
    for (int i = 0; i < 17; i++) begin
      xfer(8'(i), 8'h80, hi);
      if (i < 16) wr(`SPMP_ADDR_CTRL, 8'h03);
    end
    rck("status", `SPMP_ADDR_CTRL, 8'h93);
    for (int i = 0; i < 16; i++) rck("data", `SPMP_ADDR_DAT, 8'((i << 1) | 1));
    rck("empty", `SPMP_ADDR_DAT, 8'h00);
    // Slave transfer with frame length left at one bit
    wr(`SPMP_ADDR_CTRL, 8'h01);
    wr(`SPMP_ADDR_DAT, 8'hA5);
    drive_slave(8'h3C, got);
    chk("slave miso", 16'h00A5, {8'h00, got});
    wait_done(hi);
    rck("status", `SPMP_ADDR_CTRL, 8'h81);
    rck("data", `SPMP_ADDR_DAT, 8'h3C);
    // Select pulled low while master
    wr(`SPMP_ADDR_CTRL, 8'h03);
    nss_i <= 1'b0;
    repeat (2) @(posedge clk_sys);
    wait_done(hi);
    rck("fault", `SPMP_ADDR_CTRL, 8'h24);
    chk("oe off", 16'h0000, {13'h0000, sck_oe, mosi_oe, miso_oe});
    nss_i <= 1'b1;
    results();
  end
endmodule : spmp_top_bench
